// file: spi_status_pkg.sv
// Register map, field positions, reset values and codes for the status block.
package spi_status_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_DEBUG_CONTROL = 8'h08;
	localparam logic [7:0] OFS_RATE_DIVISOR = 8'h0a;
	localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h0c;
	localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h0d;
	localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0e;
	localparam logic [7:0] OFS_UNIT_STATUS = 8'h10;
	localparam logic [7:0] OFS_SLAVE_MATCH_CONFIG = 8'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_HALT_ON_DEBUG = 0;
	localparam int BIT_RECEIVE_COMPLETE = 2;
	localparam int BIT_TRANSMIT_COMPLETE = 1;
	localparam int BIT_DATA_REGISTER_EMPTY = 0;
	localparam int BIT_SYNC_BUSY_A = 15;
	localparam int BIT_BUFFER_OVERFLOW = 2;
	localparam int POS_MATCH_ADDR = 0;
	localparam int POS_MATCH_MASK = 16;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DEBUG_CONTROL = 8'h00;
	localparam logic [7:0] RST_RATE_DIVISOR = 8'h00;
	localparam logic [2:0] RST_IRQ_ENABLE = 3'h0;
	localparam logic [7:0] RST_MATCH_FIELD = 8'h00;

	// ------------------------------------------------------------
	// Slave match modes
	// ------------------------------------------------------------
	localparam logic [1:0] MATCH_MASK = 2'h0;
	localparam logic [1:0] MATCH_TWO_ADDRS = 2'h1;
	localparam logic [1:0] MATCH_RANGE = 2'h2;

	// ------------------------------------------------------------
	// Receive transaction states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TXN_IDLE,
		TXN_ACCEPT,
		TXN_DROP
	} txn_e;

endpackage

// file: rate_generator.sv
// Serial clock generator driven by the rate divisor, with debug halt.
module rate_generator
	import spi_status_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic run_i,
	input wire logic halt_i,
	input wire logic [WIDTH-1:0] divisor_i,
	output logic tick_o,
	output logic sck_o
);

	logic [WIDTH-1:0] count;
	logic sck;
	logic tick;
	wire at_end = (count == divisor_i);
	wire advance = run_i && !halt_i;

	// Half period is divisor plus one cycles, so the serial clock is ref / (2 * (divisor + 1)).
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count <= '0;
			sck <= 1'b0;
			tick <= 1'b0;
		end else if (!run_i) begin
			count <= '0;
			sck <= 1'b0;
			tick <= 1'b0;
		end else if (advance) begin
			count <= at_end ? '0 : count + 1'b1;
			sck <= at_end ? !sck : sck;
			tick <= at_end;
		end else begin
			tick <= 1'b0;
		end
	end

	assign tick_o = tick;
	assign sck_o = sck;

endmodule

// file: spi_status_interrupt_regs.sv
// Status, interrupt, debug and slave address match registers of the serial unit.
// How it works
// (R1) Debug stop halts the rate generator.
// (R2) Eight-bit divisor, writable only while disabled.
// (R3) Enable-clear writes one to clear; reads enables.
// (R4) Enable-set writes one to set enables.
// (R5) Receive bit 2, transmit bit 1, empty bit 0.
// (R6) Receive flag while unread; cleared by read, disable.
// (R7) Matched address is first received item.
// (R8) Master: transmit flag when shifted, nothing waiting.
// (R9) Slave: transmit flag on select high, matched.
// (R10) Transmit flag cleared by write one, new data.
// (R11) Empty flag set when free, cleared by data.
// (R12) Sync busy bit 15 while crossing domains.
// (R13) Overflow bit 2 set on overflow, write-one clears.
// (R14) Overflow belongs to next unread character.
// (R15) Overflowed character reads as zero.
// (R16) Match mask 23:16, address 7:0, protected.
// (R17) Immediate notify sets overflow now, else in-stream.
// (R18) Match mode: mask, two addresses, or range.
// (R19) Interrupt when any enabled flag is set.
module spi_status_interrupt_regs
	import spi_status_pkg::*;
#(
	parameter int CHAR_WIDTH = 9,
	parameter int RX_DEPTH = 2
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	input wire logic unit_enable_i,
	input wire logic rx_enable_i,
	input wire logic master_mode_i,
	input wire logic debug_halted_i,
	input wire logic immediate_overflow_notify_i,
	input wire logic match_enable_i,
	input wire logic [1:0] slave_match_mode_i,
	input wire logic sync_pending_i,
	input wire logic rx_char_valid_i,
	input wire logic [CHAR_WIDTH-1:0] rx_char_i,
	input wire logic select_high_i,
	input wire logic shift_done_i,
	input wire logic tx_taken_i,
	input wire logic data_write_i,
	input wire logic data_read_i,
	output logic [CHAR_WIDTH-1:0] received_word_o,
	output logic rate_tick_o,
	output logic sck_gen_o,
	output logic irq_o
);

	localparam int PTR_W = $clog2(RX_DEPTH);
	localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(RX_DEPTH);

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic halt_on_debug;
	logic [7:0] rate_divisor;
	logic [2:0] irq_enable;
	logic receive_complete;
	logic transmit_complete;
	logic data_register_empty;
	logic sync_busy_a;
	logic buffer_overflow;
	logic buffer_overflow_seen;
	logic [7:0] match_addr;
	logic [7:0] match_mask_or_second;
	logic [31:0] rdata;
	txn_e txn_state;
	txn_e next_txn_state;
	logic txn_matched;

	// ------------------------------------------------------------
	// Receive buffer storage
	// ------------------------------------------------------------
	logic [CHAR_WIDTH-1:0] rx_data [RX_DEPTH];
	logic [RX_DEPTH-1:0] rx_ovf;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W:0] rx_count;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	wire sel_debug = (reg_addr_i == OFS_DEBUG_CONTROL);
	wire sel_rate = (reg_addr_i == OFS_RATE_DIVISOR);
	wire sel_en_clr = (reg_addr_i == OFS_IRQ_ENABLE_CLEAR);
	wire sel_en_set = (reg_addr_i == OFS_IRQ_ENABLE_SET);
	wire sel_flags = (reg_addr_i == OFS_IRQ_FLAGS);
	wire sel_status = (reg_addr_i == OFS_UNIT_STATUS);
	wire sel_match = (reg_addr_i == OFS_SLAVE_MATCH_CONFIG);

	wire wr_debug = reg_write_i && sel_debug;
	// Divisor and match writes are discarded while the unit is enabled.
	wire wr_rate = reg_write_i && sel_rate && !unit_enable_i;
	wire wr_match = reg_write_i && sel_match && !unit_enable_i;
	wire wr_en_clr = reg_write_i && sel_en_clr;
	wire wr_en_set = reg_write_i && sel_en_set;
	wire wr_flags = reg_write_i && sel_flags;
	wire wr_status = reg_write_i && sel_status;

	wire [2:0] en_clr_bits = wr_en_clr ? reg_wdata_i[2:0] : 3'h0;
	wire [2:0] en_set_bits = wr_en_set ? reg_wdata_i[2:0] : 3'h0;
	wire clear_tc_sw = wr_flags && reg_wdata_i[BIT_TRANSMIT_COMPLETE];
	wire clear_ovf_sw = wr_status && reg_wdata_i[BIT_BUFFER_OVERFLOW];

	// ------------------------------------------------------------
	// Slave address match
	// ------------------------------------------------------------
	wire [7:0] cand = rx_char_i[7:0];
	wire hit_mask = ((cand ^ match_addr) & ~match_mask_or_second) == 8'h00;
	wire hit_two = (cand == match_addr) || (cand == match_mask_or_second);
	wire hit_range = (cand <= match_addr) && (cand >= match_mask_or_second);
	// Mode 3 is reserved and never matches, so such a transaction is dropped.
	wire addr_hit = (slave_match_mode_i == MATCH_MASK) ? hit_mask : // R18
		(slave_match_mode_i == MATCH_TWO_ADDRS) ? hit_two : // R18
		(slave_match_mode_i == MATCH_RANGE) ? hit_range : 1'b0; // R18
	wire use_match = match_enable_i && !master_mode_i;
	wire first_char = rx_char_valid_i && (txn_state == TXN_IDLE);

	always_comb begin
		next_txn_state = txn_state;
		case (txn_state)
			TXN_IDLE: begin
				if (first_char && use_match) begin
					next_txn_state = addr_hit ? TXN_ACCEPT : TXN_DROP;
				end else if (first_char) begin
					next_txn_state = TXN_ACCEPT;
				end
			end
			TXN_ACCEPT, TXN_DROP: begin
				if (select_high_i || !rx_enable_i) begin
					next_txn_state = TXN_IDLE;
				end
			end
			default: begin
				next_txn_state = TXN_IDLE;
			end
		endcase
	end

	// An unmatched transaction is dropped whole, address included.
	wire drop_char = (txn_state == TXN_DROP) || (first_char && use_match && !addr_hit);
	// The matched address enters the buffer like any data character.
	wire accept_char = rx_enable_i && rx_char_valid_i && !drop_char; // R7

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			txn_state <= TXN_IDLE;
			txn_matched <= 1'b0;
		end else begin
			txn_state <= next_txn_state;
			if (first_char) begin
				txn_matched <= !use_match || addr_hit;
			end
		end
	end

	// ------------------------------------------------------------
	// Receive buffer
	// ------------------------------------------------------------
	wire rx_full = (rx_count == DEPTH_CNT);
	wire rx_empty = (rx_count == '0);
	wire pop = data_read_i && !rx_empty;
	wire push = accept_char && !rx_full;
	// A character arriving on a full buffer is lost; without a pop in that cycle
	// the newest slot stands for it, reading zero with its overflow mark.
	wire overflow = accept_char && rx_full && !pop;
	wire [PTR_W-1:0] last_ptr = wr_ptr - 1'b1;
	wire next_head_ovf = rx_ovf[PTR_W'(rd_ptr + 1'b1)];
	wire rx_flush = !rx_enable_i;

	generate
		for (genvar i = 0; i < RX_DEPTH; i++) begin : g_slot
			wire wr_here = push && (wr_ptr == PTR_W'(i));
			wire ovf_here = overflow && (last_ptr == PTR_W'(i));
			always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					rx_data[i] <= '0;
					rx_ovf[i] <= 1'b0;
				end else if (rx_flush) begin
					rx_ovf[i] <= 1'b0;
				end else if (ovf_here) begin
					rx_data[i] <= '0; // R15
					rx_ovf[i] <= 1'b1; // R14
				end else if (wr_here) begin
					rx_data[i] <= rx_char_i;
					rx_ovf[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			rx_count <= '0;
		end else if (rx_flush) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			rx_count <= '0;
		end else begin
			rd_ptr <= pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
			wr_ptr <= push ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
			rx_count <= rx_count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

	// ------------------------------------------------------------
	// Overflow status
	// ------------------------------------------------------------
	// In-stream notification: the bit rises when the overflowed slot
	// becomes the next one to read, either now or after a pop.
	wire ovf_in_stream = !immediate_overflow_notify_i &&
		((pop && next_head_ovf) ||
		(overflow && rx_count == 1 && !pop) ||
		(!pop && !rx_empty && rx_ovf[rd_ptr] && !buffer_overflow_seen));
	wire set_ovf = (immediate_overflow_notify_i && overflow) || ovf_in_stream; // R17

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			buffer_overflow <= 1'b0;
			buffer_overflow_seen <= 1'b0;
		end else if (rx_flush) begin
			buffer_overflow <= 1'b0; // R13
			buffer_overflow_seen <= 1'b0;
		end else begin
			// Set wins over a write-one clear in the same cycle.
			buffer_overflow <= set_ovf || (buffer_overflow && !clear_ovf_sw); // R13
			buffer_overflow_seen <= pop ? 1'b0 : (buffer_overflow_seen || set_ovf);
		end
	end

	// ------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------
	wire tc_master = master_mode_i && shift_done_i && data_register_empty; // R8
	wire tc_slave = !master_mode_i && select_high_i && (!use_match || txn_matched); // R9
	wire set_tc = tc_master || tc_slave;
	wire clear_tc = clear_tc_sw || data_write_i; // R10

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			transmit_complete <= 1'b0;
			data_register_empty <= 1'b1;
			receive_complete <= 1'b0;
			sync_busy_a <= 1'b0;
		end else begin
			transmit_complete <= set_tc || (transmit_complete && !clear_tc); // R10
			// Flag writes never touch the empty flag.
			data_register_empty <= tx_taken_i || (data_register_empty && !data_write_i); // R11
			// Taken from the count after this edge, so the flag never lags a pop.
			receive_complete <= !rx_flush && ((rx_count + (PTR_W+1)'(push)
				- (PTR_W+1)'(pop)) != '0); // R6
			// Bit 15 is read-only here and follows the pending input one cycle late.
			sync_busy_a <= sync_pending_i; // R12
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			halt_on_debug <= RST_DEBUG_CONTROL[BIT_HALT_ON_DEBUG];
			rate_divisor <= RST_RATE_DIVISOR;
			irq_enable <= RST_IRQ_ENABLE;
			match_addr <= RST_MATCH_FIELD;
			match_mask_or_second <= RST_MATCH_FIELD;
		end else begin
			if (wr_debug) begin
				halt_on_debug <= reg_wdata_i[BIT_HALT_ON_DEBUG];
			end
			if (wr_rate) begin
				rate_divisor <= reg_wdata_i[7:0]; // R2
			end
			irq_enable <= (irq_enable & ~en_clr_bits) | en_set_bits; // R3 R4
			if (wr_match) begin
				match_addr <= reg_wdata_i[POS_MATCH_ADDR +: 8]; // R16
				match_mask_or_second <= reg_wdata_i[POS_MATCH_MASK +: 8]; // R16
			end
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	wire [2:0] flag_bits = {receive_complete, transmit_complete, data_register_empty}; // R5
	wire [15:0] status_bits = (16'(sync_busy_a) << BIT_SYNC_BUSY_A) |
		(16'(buffer_overflow) << BIT_BUFFER_OVERFLOW);
	wire [31:0] match_bits = (32'(match_mask_or_second) << POS_MATCH_MASK) |
		(32'(match_addr) << POS_MATCH_ADDR);
	wire [31:0] read_mux = sel_debug ? 32'(halt_on_debug) :
		sel_rate ? 32'(rate_divisor) :
		(sel_en_clr || sel_en_set) ? 32'(irq_enable) : // R3
		sel_flags ? 32'(flag_bits) :
		sel_status ? 32'(status_bits) :
		sel_match ? match_bits : 32'h0000_0000;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata <= 32'h0000_0000;
			received_word_o <= '0;
		end else begin
			rdata <= reg_read_i ? read_mux : rdata;
			received_word_o <= rx_data[rd_ptr];
		end
	end

	assign reg_rdata_o = rdata;

	// ------------------------------------------------------------
	// Interrupt request
	// ------------------------------------------------------------
	assign irq_o = |(flag_bits & irq_enable); // R19

	// ------------------------------------------------------------
	// Rate generator
	// ------------------------------------------------------------
	// Only a master makes the serial clock; a slave takes it from the far side.
	wire gen_run = unit_enable_i && master_mode_i;
	// The halt needs both the stop bit and a halted processor.
	wire gen_halt = halt_on_debug && debug_halted_i; // R1

	rate_generator #(
		.WIDTH(8)
	) rate_generator_inst (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.run_i(gen_run),
		.halt_i(gen_halt), // R1
		.divisor_i(rate_divisor), // R2
		.tick_o(rate_tick_o),
		.sck_o(sck_gen_o)
	);

endmodule

// file: spi_status_interrupt_regs_properties.sv
// Port-level checker for the status, interrupt and address match register block.
module spi_status_checker (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic unit_enable_i,
	input wire logic debug_halted_i,
	input wire logic sync_pending_i,
	input wire logic rate_tick_o,
	input wire logic sck_gen_o,
	input wire logic irq_o
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	logic halt_on_debug;
	wire logic mapped;
	assign mapped = reg_addr_i inside {8'h08, 8'h0a, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h14};
	// The halt bit is mirrored here because the generator's freeze depends on it.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			halt_on_debug <= 1'b0;
		end else if (reg_write_i && reg_addr_i == 8'h08) begin
			halt_on_debug <= reg_wdata_i[0];
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_unmapped;
		reg_read_i && !mapped |=> reg_rdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_flag_bits;
		reg_read_i && reg_addr_i == 8'h0e |=> reg_rdata_o[31:3] == 29'h0;
	endproperty
	a_flag_bits: assert property (p_flag_bits) else $error("unused flag bits set");
	property p_match_fields;
		reg_read_i && reg_addr_i == 8'h14 |=> reg_rdata_o[31:24] == 8'h00 && reg_rdata_o[15:8] == 8'h00;
	endproperty
	a_match_fields: assert property (p_match_fields) else $error("match config spare bits");
	property p_divisor_width;
		reg_read_i && reg_addr_i == 8'h0a |=> reg_rdata_o[31:8] == 24'h0;
	endproperty
	a_divisor_width: assert property (p_divisor_width) else $error("divisor wider than 8");
	property p_sync_busy;
		reg_read_i && reg_addr_i == 8'h10 |=> reg_rdata_o[15] == $past(sync_pending_i, 2)
			&& reg_rdata_o[31:16] == 16'h0 && reg_rdata_o[14:3] == 12'h0 && reg_rdata_o[1:0] == 2'h0;
	endproperty
	a_sync_busy: assert property (p_sync_busy) else $error("status busy bit wrong");
	property p_clear_all;
		reg_write_i && reg_addr_i == 8'h0c && reg_wdata_i[2:0] == 3'h7 |=> !irq_o;
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("irq after clearing enables");
	property p_enables_mirror;
		reg_read_i && reg_addr_i == 8'h0c && !reg_write_i ##1 !reg_write_i && !reg_read_i
			##1 reg_read_i && reg_addr_i == 8'h0d && !reg_write_i |=> reg_rdata_o == $past(reg_rdata_o);
	endproperty
	a_enables_mirror: assert property (p_enables_mirror) else $error("enable views differ");
	property p_debug_halt;
		(halt_on_debug && debug_halted_i) [*2] |-> !rate_tick_o && $stable(sck_gen_o);
	endproperty
	a_debug_halt: assert property (p_debug_halt) else $error("generator ran in halt");
	property p_idle_sck;
		!unit_enable_i [*3] |-> !sck_gen_o && !rate_tick_o;
	endproperty
	a_idle_sck: assert property (p_idle_sck) else $error("clock while disabled");
	c_tick: cover property (rate_tick_o);
	c_halt: cover property (halt_on_debug && debug_halted_i);
	c_irq: cover property (reg_read_i && reg_addr_i == 8'h0e ##1 irq_o);
endmodule

bind spi_status_interrupt_regs spi_status_checker spi_status_checker_inst (
	.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
	.reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .unit_enable_i(unit_enable_i), .debug_halted_i(debug_halted_i),
	.sync_pending_i(sync_pending_i), .rate_tick_o(rate_tick_o), .sck_gen_o(sck_gen_o),
	.irq_o(irq_o));

// file: spi_far_end.sv
// Behavioural far-side serial device that feeds characters and frame events.
module spi_far_end (
	input wire logic sys_clk_i,
	output logic rx_char_valid_o,
	output logic [8:0] rx_char_o,
	output logic select_high_o,
	output logic shift_done_o,
	output logic tx_taken_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rx_char_valid_o = 1'b0;
		rx_char_o = 9'h1ff;
		{select_high_o, shift_done_o, tx_taken_o} = 3'h0;
	end
	// Idle data is the inverse of the last character, so stale data never looks fresh.
	task automatic send(input logic [8:0] c, input int gap);
		@(negedge sys_clk_i);
		rx_char_valid_o = 1'b1;
		rx_char_o = c;
		@(negedge sys_clk_i);
		rx_char_valid_o = 1'b0;
		rx_char_o = ~c;
		repeat (gap) @(negedge sys_clk_i);
	endtask
	// One-cycle events: select released, shift finished, shift register loaded.
	task automatic strobe(input logic [2:0] ev);
		@(negedge sys_clk_i);
		{select_high_o, shift_done_o, tx_taken_o} = ev;
		@(negedge sys_clk_i);
		{select_high_o, shift_done_o, tx_taken_o} = 3'h0;
	endtask
endmodule

// file: spi_status_interrupt_regs_tb_top.sv
// Self-checking bench for the status, interrupt and address match registers.
module spi_status_interrupt_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, wen, ren, unit_en, rx_en, master, dbg, immediate_overflow_notify, match_en, sync, dwr, drd;
	logic [7:0] addr;
	logic [31:0] wdata, reg_rdata_o;
	logic [1:0] mode;
	logic [8:0] received_word_o, rx_char;
	logic rx_valid, sel_hi, shift_done, taken, rate_tick_o, sck_gen_o, irq_o;
	int error_cnt, check_count, n;
	logic [7:0] ofs [7] = '{8'h08, 8'h0a, 8'h0c, 8'h0d, 8'h10, 8'h14, 8'h18};
	logic [10:0] mt [6] = '{11'h440, 11'h041, 11'h510, 11'h620, 11'h241, 11'h340};
	spi_status_interrupt_regs spi_status_interrupt_regs_inst (
		.sys_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_write_i(wen),
		.reg_read_i(ren), .reg_wdata_i(wdata), .reg_rdata_o(reg_rdata_o),
		.unit_enable_i(unit_en), .rx_enable_i(rx_en), .master_mode_i(master),
		.debug_halted_i(dbg), .immediate_overflow_notify_i(immediate_overflow_notify), .match_enable_i(match_en),
		.slave_match_mode_i(mode), .sync_pending_i(sync), .rx_char_valid_i(rx_valid),
		.rx_char_i(rx_char), .select_high_i(sel_hi), .shift_done_i(shift_done),
		.tx_taken_i(taken), .data_write_i(dwr), .data_read_i(drd),
		.received_word_o(received_word_o), .rate_tick_o(rate_tick_o),
		.sck_gen_o(sck_gen_o), .irq_o(irq_o));
	spi_far_end spi_far_end_inst (.sys_clk_i(clk), .rx_char_valid_o(rx_valid),
		.rx_char_o(rx_char), .select_high_o(sel_hi), .shift_done_o(shift_done),
		.tx_taken_o(taken));
	always #50 clk = ~clk;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic test_done;
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wen = 1;
		@(negedge clk);
		wen = 0;
	endtask
	// Read data is registered on the read edge, so it is compared at the next falling edge.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk);
		addr = a;
		ren = 1;
		@(negedge clk);
		ren = 0;
		chk(reg_rdata_o, e);
	endtask
	task automatic sw_data(input logic w);
		@(negedge clk);
		dwr = w;
		drd = !w;
		@(negedge clk);
		dwr = 0;
		drd = 0;
	endtask
	task automatic tick_gap(output int g);
		g = 0;
		while (rate_tick_o !== 1'b1 && g < 300) begin
			@(negedge clk);
			g++;
		end
		g = 0;
		do begin
			@(negedge clk);
			g++;
		end while (rate_tick_o !== 1'b1 && g < 300);
	endtask
	task automatic count_ticks(output int c);
		c = 0;
		repeat (12) begin
			@(negedge clk);
			c += (rate_tick_o === 1'b1);
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 0;
		{rst_b, wen, ren, unit_en, master, dbg, match_en, sync, dwr, drd} = '0;
		{rx_en, immediate_overflow_notify} = 2'b11;
		{addr, wdata, mode} = '0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst_b = 1;
		foreach (ofs[i]) rd(ofs[i], 32'h0);
		rd(8'h0e, 32'h1);
		wr(8'h0d, 32'h7);
		chk(irq_o, 1);
		wr(8'h0c, 32'h1);
		chk(irq_o, 0);
		wr(8'h0d, 32'h0);
		rd(8'h0c, 32'h6);
		rd(8'h0d, 32'h6);
		wr(8'h0a, 32'h3);
		wr(8'h14, 32'hff10ff40);
		unit_en = 1;
		wr(8'h0a, 32'h55);
		wr(8'h14, 32'h0);
		rd(8'h0a, 32'h3);
		rd(8'h14, 32'h00100040);
		master = 1;
		tick_gap(n);
		chk(n, 4);
		wr(8'h08, 32'h1);
		dbg = 1;
		count_ticks(n);
		chk(n, 0);
		rd(8'h08, 32'h1);
		wr(8'h08, 32'h0);
		count_ticks(n);
		chk(n, 3);
		dbg = 0;
		sync = 1;
		rd(8'h10, 32'h8000);
		sync = 0;
		rd(8'h10, 32'h0);
		spi_far_end_inst.send(9'h055, 1);
		chk(received_word_o, 32'h55);
		chk(irq_o, 1);
		wr(8'h0e, 32'h5);
		rd(8'h0e, 32'h5);
		sw_data(0);
		rd(8'h0e, 32'h1);
		for (int m = 0; m < 2; m++) begin
			immediate_overflow_notify = !m;
			spi_far_end_inst.send(9'h101, 0);
			spi_far_end_inst.send(9'h0a2, 0);
			spi_far_end_inst.send(9'h0c3, 1);
			rd(8'h10, immediate_overflow_notify ? 32'h4 : 32'h0);
			chk(received_word_o, 32'h101);
			sw_data(0);
			@(negedge clk);
			chk(received_word_o, 32'h0);
			rd(8'h10, 32'h4);
			wr(8'h10, 32'h0);
			rd(8'h10, 32'h4);
			if (m == 0) begin
				wr(8'h10, 32'h4);
				rd(8'h10, 32'h0);
			end
			rx_en = 0;
			rd(8'h10, 32'h0);
			rd(8'h0e, 32'h1);
			rx_en = 1;
		end
		master = 1;
		sw_data(1);
		rd(8'h0e, 32'h0);
		spi_far_end_inst.strobe(3'b010);
		rd(8'h0e, 32'h0);
		spi_far_end_inst.strobe(3'b001);
		rd(8'h0e, 32'h1);
		spi_far_end_inst.strobe(3'b010);
		rd(8'h0e, 32'h3);
		wr(8'h0e, 32'h0);
		rd(8'h0e, 32'h3);
		wr(8'h0e, 32'h2);
		rd(8'h0e, 32'h1);
		spi_far_end_inst.strobe(3'b010);
		sw_data(1);
		rd(8'h0e, 32'h0);
		spi_far_end_inst.strobe(3'b001);
		wr(8'h0c, 32'h7);
		chk(irq_o, 0);
		master = 0;
		match_en = 1;
		foreach (mt[i]) begin
			mode = mt[i][9:8];
			spi_far_end_inst.send({1'b0, mt[i][7:0]}, 1);
			spi_far_end_inst.send(9'h033, 1);
			spi_far_end_inst.strobe(3'b100);
			rd(8'h0e, mt[i][10] ? 32'h7 : 32'h1);
			if (mt[i][10]) begin
				chk(received_word_o, {24'h0, mt[i][7:0]});
				sw_data(0);
				sw_data(0);
				wr(8'h0e, 32'h2);
			end
		end
		unit_en = 0;
		match_en = 0;
		wr(8'h0a, 32'h5a);
		rd(8'h0a, 32'h5a);
		rst_b = 0;
		@(negedge clk);
		rst_b = 1;
		rd(8'h0a, 32'h0);
		rd(8'h0e, 32'h1);
		test_done();
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		test_done();
	end
endmodule
